// ===== dmp_pkg.sv
// Constants, carriers and decode helpers for the multiply/prefetch unit.
// Assumes one core clock and a 24-bit instruction word from the decoder.
package dmp_pkg;

    // Opcode fields
    localparam logic [11:0] PAGE_LIT_OPC = 12'hfec;
    localparam logic [11:0] PAGE_REG_OPC = 12'hfed;
    localparam logic [3:0] MULT_OPC = 4'hc;
    localparam logic [3:0] SQUARE_OPC = 4'hf;
    localparam logic [2:0] PREFETCH_M = 3'h7;
    localparam logic [2:0] MULT_M_BAD = 3'h6;
    localparam logic [1:0] SQUARE_HI = 2'h0;
    localparam logic [1:0] MULT_TAIL = 2'h3;

    // Page selector and write-back codes
    localparam logic [1:0] PP_READ = 2'h0;
    localparam logic [1:0] PP_WRITE = 2'h1;
    localparam logic [1:0] PP_TABLE = 2'h2;
    localparam logic [1:0] AWB_REG = 2'h0;
    localparam logic [1:0] AWB_MEM = 2'h1;

    // Working register indices and steps
    localparam logic [3:0] W8 = 4'h8;
    localparam logic [3:0] W9 = 4'h9;
    localparam logic [3:0] W10 = 4'ha;
    localparam logic [3:0] W11 = 4'hb;
    localparam logic [3:0] W12 = 4'hc;
    localparam logic [3:0] W13 = 4'hd;
    localparam logic [1:0] DEST_BASE = 2'h1;
    localparam logic [15:0] WB_STEP = 16'h0002;

    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] RPAGE_OFS = 8'h04;
    localparam logic [7:0] WPAGE_OFS = 8'h08;
    localparam logic [7:0] TPAGE_OFS = 8'h0c;
    localparam logic [7:0] ACC0_LO_OFS = 8'h10;
    localparam logic [7:0] ACC0_HI_OFS = 8'h14;
    localparam logic [7:0] ACC1_LO_OFS = 8'h18;
    localparam logic [7:0] ACC1_HI_OFS = 8'h1c;
    localparam logic [7:0] FLAGS_OFS = 8'h20;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
    localparam logic [7:0] IRQ_EN_OFS = 8'h28;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h2c;

    // Reset values and bit positions
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam int INT_SEL_BIT = 0;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_PAGE_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        op_none = 3'h0,
        op_page_lit = 3'h1,
        op_page_reg = 3'h2,
        op_prefetch = 3'h3,
        op_mult = 3'h4,
        op_square = 3'h5
    } dmp_op_t;

    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic [15:0] data;
    } dmp_wr_port_t;

    typedef struct packed {
        logic en;
        logic [15:0] addr;
        logic [15:0] data;
    } dmp_mem_req_t;

    function automatic dmp_op_t decode_op(input logic [23:0] iw);
        dmp_op_t r;
        r = op_none;
        if (iw[23:12] == PAGE_LIT_OPC) begin
            r = op_page_lit;
        end else if (iw[23:12] == PAGE_REG_OPC && iw[9:4] == 6'h00) begin
            r = op_page_reg;
        end else if (iw[23:20] == MULT_OPC && !iw[19] && !iw[14]) begin
            if (iw[18:16] == PREFETCH_M) begin
                r = op_prefetch;
            end else if (iw[18:16] != MULT_M_BAD && iw[1:0] == MULT_TAIL) begin
                r = op_mult;
            end
        end else if (iw[23:20] == SQUARE_OPC && iw[19:18] == SQUARE_HI && !iw[14]) begin
            r = op_square;
        end
        return r;
    endfunction : decode_op

    // Upper word rounded on bit 15
    function automatic logic [15:0] round_hi(input logic [39:0] acc);
        return acc[31:16] + {15'h0000, acc[15]};
    endfunction : round_hi

    // Value no longer fits bits 31:0 as a signed number
    function automatic logic acc_ovf(input logic [39:0] acc);
        return !((&acc[39:31]) || !(|acc[39:31]));
    endfunction : acc_ovf

endpackage : dmp_pkg

// ===== dmp_prefetch_agen.sv
// Prefetch address generator for one operand path (X or Y).
// Assumes the caller gates the outputs with an active prefetch instruction.
`timescale 1ns/100ps
module dmp_prefetch_agen (
    input wire logic [3:0] mode,
    input wire logic [15:0] ptr_lo,
    input wire logic [15:0] ptr_hi,
    input wire logic [15:0] offset,
    output logic fetch,
    output logic [15:0] addr,
    output logic ptr_upd,
    output logic ptr_sel_hi,
    output logic [15:0] ptr_next
);
    logic [15:0] base;
    logic [15:0] step;

    assign base = mode[3] ? ptr_hi : ptr_lo;
    assign ptr_sel_hi = mode[3];

    always_comb begin
        step = 16'h0000;
        fetch = 1'b1;
        addr = base;
        unique case (mode[2:0])
            3'h1: step = 16'h0002;
            3'h2: step = 16'h0004;
            3'h3: step = 16'h0006;
            3'h5: step = 16'hfffa;
            3'h6: step = 16'hfffc;
            3'h7: step = 16'hfffe;
            3'h4: begin
                // Low pointer: no prefetch; high pointer: offset, pointer kept
                fetch = mode[3];
                addr = base + offset;
            end
            3'h0: step = 16'h0000;
        endcase
    end

    // Operand read at the old address, pointer moved by the step
    assign ptr_upd = fetch && (step != 16'h0000);
    assign ptr_next = base + step;
endmodule : dmp_prefetch_agen

// ===== dmp_unit.sv
// Execution unit for page loads, operand prefetch/store and multiply/square
// into two 40-bit accumulators, with an AXI4-Lite register port.
// Assumes register file and data memory on aclk; memory reads answer one
// cycle after the request; the decoder spaces dependent instructions.
//
// Contract
// - Literal page load writes 10, 9 or 8 literal bits to selected page.
// - Register page load copies low 10, 9 or 8 source bits to page.
// - Prefetch-store does no arithmetic; A names the accumulator not written back.
// - X prefetch via W8/W9 into W4-W7: plain, step of +-2/4/6, or W12 offset.
// - Y prefetch via W10/W11 into W4-W7 with the same addressing choices.
// - Post-modify fetches at the old pointer, then steps the pointer.
// - Write-back field selects none, W13, or memory at W13 then W13 plus 2.
// - Memory write-back stores rounded other accumulator at W13, then W13 += 2.
// - Signed 32-bit product, sign-extended to 40 bits, overwrites chosen accumulator.
// - Control register zero means fractional: product shifted left one place.
// - Control bit 0 set means integer: unshifted sign-extended product.
// - Square multiplies one of W4-W7 by itself, with the same prefetches.
`timescale 1ns/100ps
module dmp_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic [15:0][15:0] wreg_file,
    input wire logic [15:0] x_rd_data,
    input wire logic [15:0] y_rd_data,
    output dmp_pkg::dmp_wr_port_t wr_xd,
    output dmp_pkg::dmp_wr_port_t wr_yd,
    output dmp_pkg::dmp_wr_port_t wr_xptr,
    output dmp_pkg::dmp_wr_port_t wr_yptr,
    output dmp_pkg::dmp_wr_port_t wr_w13,
    output dmp_pkg::dmp_mem_req_t x_rd,
    output dmp_pkg::dmp_mem_req_t y_rd,
    output dmp_pkg::dmp_mem_req_t mem_wr,
    output logic [9:0] data_read_page,
    output logic [8:0] data_write_page,
    output logic [7:0] table_page,
    output logic [3:0] acc_flags,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    dmp_pkg::dmp_op_t op;
    logic a_sel;
    logic [1:0] acc_write_back_dest;
    logic [15:0] mul_a;
    logic [15:0] mul_b;
    logic signed [31:0] prod;
    logic [39:0] acc_new;
    logic [39:0] acc_q [2];
    logic [39:0] next_acc [2];
    logic [15:0] core_control_reg;
    logic pf_act;
    logic pf_fetch [2];
    logic [15:0] pf_addr [2];
    logic pf_upd [2];
    logic pf_hi [2];
    logic [15:0] pf_next [2];
    logic [3:0] pend_idx [2];
    logic pend_en [2];
    logic [15:0] wb_val;
    logic [15:0] w13;
    logic [1:0] page_sel;
    logic [9:0] page_val;
    logic [dmp_pkg::IRQ_W-1:0] irq_status;
    logic [dmp_pkg::IRQ_W-1:0] irq_enable;
    logic [dmp_pkg::IRQ_W-1:0] irq_event;
    logic [dmp_pkg::IRQ_W-1:0] irq_clr;
    logic [dmp_pkg::IRQ_W-1:0] next_status;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_commit;
    logic wr_hit;

    // Decode
    assign op = instr_valid ? dmp_pkg::decode_op(instr_word) : dmp_pkg::op_none;
    assign a_sel = instr_word[15];
    assign acc_write_back_dest = instr_word[1:0];
    assign w13 = wreg_file[dmp_pkg::W13];
    assign pf_act = (op == dmp_pkg::op_prefetch) || (op == dmp_pkg::op_mult)
                    || (op == dmp_pkg::op_square);
    assign page_sel = instr_word[11:10];
    assign page_val = (op == dmp_pkg::op_page_lit) ? instr_word[9:0]
                      : wreg_file[instr_word[3:0]][9:0];

    // Operand pair or squared register
    always_comb begin
        mul_a = wreg_file[4];
        mul_b = wreg_file[5];
        if (op == dmp_pkg::op_square) begin
            mul_a = wreg_file[{2'h1, instr_word[17:16]}];
            mul_b = mul_a;
        end else begin
            unique case (instr_word[18:16])
                3'h1: mul_b = wreg_file[6];
                3'h2: mul_b = wreg_file[7];
                3'h3: begin
                    mul_a = wreg_file[5];
                    mul_b = wreg_file[6];
                end
                3'h4: begin
                    mul_a = wreg_file[5];
                    mul_b = wreg_file[7];
                end
                3'h5: begin
                    mul_a = wreg_file[6];
                    mul_b = wreg_file[7];
                end
                default: mul_b = wreg_file[5];
            endcase
        end
    end

    assign prod = $signed(mul_a) * $signed(mul_b);
    assign acc_new = core_control_reg[dmp_pkg::INT_SEL_BIT] ?
                     {{8{prod[31]}}, prod} :
                     {{7{prod[31]}}, prod, 1'b0};

    always_comb begin
        next_acc[0] = acc_q[0];
        next_acc[1] = acc_q[1];
        if (op == dmp_pkg::op_mult || op == dmp_pkg::op_square) begin
            next_acc[a_sel] = acc_new;
        end
    end

    // Accumulators and flags; prefetch-store leaves both alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q[0] <= 40'h0000000000;
            acc_q[1] <= 40'h0000000000;
            acc_flags <= 4'h0;
        end else if (op == dmp_pkg::op_mult || op == dmp_pkg::op_square) begin
            acc_q[0] <= next_acc[0];
            acc_q[1] <= next_acc[1];
            acc_flags <= {2'b00, dmp_pkg::acc_ovf(next_acc[1]),
                          dmp_pkg::acc_ovf(next_acc[0])};
        end
    end

    // Page registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_read_page <= 10'h000;
            data_write_page <= 9'h000;
            table_page <= 8'h00;
        end else if (op == dmp_pkg::op_page_lit || op == dmp_pkg::op_page_reg) begin
            unique case (page_sel)
                dmp_pkg::PP_READ: data_read_page <= page_val;
                dmp_pkg::PP_WRITE: data_write_page <= page_val[8:0];
                dmp_pkg::PP_TABLE: table_page <= page_val[7:0];
                default: table_page <= table_page;
            endcase
        end
    end

    // X and Y prefetch paths
    generate
        for (genvar g = 0; g < 2; g++) begin : g_pf
            dmp_prefetch_agen u_agen (
                .mode(g == 0 ? instr_word[9:6] : instr_word[5:2]),
                .ptr_lo(wreg_file[g == 0 ? dmp_pkg::W8 : dmp_pkg::W10]),
                .ptr_hi(wreg_file[g == 0 ? dmp_pkg::W9 : dmp_pkg::W11]),
                .offset(wreg_file[dmp_pkg::W12]),
                .fetch(pf_fetch[g]),
                .addr(pf_addr[g]),
                .ptr_upd(pf_upd[g]),
                .ptr_sel_hi(pf_hi[g]),
                .ptr_next(pf_next[g])
            );
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pend_en[g] <= 1'b0;
                    pend_idx[g] <= 4'h0;
                end else begin
                    pend_en[g] <= pf_act && pf_fetch[g];
                    pend_idx[g] <= {dmp_pkg::DEST_BASE,
                                    g == 0 ? instr_word[13:12] : instr_word[11:10]};
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            x_rd <= '0;
            y_rd <= '0;
            wr_xptr <= '0;
            wr_yptr <= '0;
            wr_xd <= '0;
            wr_yd <= '0;
        end else begin
            x_rd <= '{en: pf_act && pf_fetch[0], addr: pf_addr[0], data: 16'h0000};
            y_rd <= '{en: pf_act && pf_fetch[1], addr: pf_addr[1], data: 16'h0000};
            wr_xptr <= '{en: pf_act && pf_upd[0], idx: pf_hi[0] ? dmp_pkg::W9 : dmp_pkg::W8,
                         data: pf_next[0]};
            wr_yptr <= '{en: pf_act && pf_upd[1], idx: pf_hi[1] ? dmp_pkg::W11 : dmp_pkg::W10,
                         data: pf_next[1]};
            wr_xd <= '{en: pend_en[0], idx: pend_idx[0], data: x_rd_data};
            wr_yd <= '{en: pend_en[1], idx: pend_idx[1], data: y_rd_data};
        end
    end

    // Write-back of the other accumulator
    assign wb_val = dmp_pkg::round_hi(acc_q[!a_sel]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_w13 <= '0;
            mem_wr <= '0;
        end else begin
            wr_w13 <= '0;
            mem_wr <= '0;
            // Only prefetch-store writes back; multiply and square never do
            if (op == dmp_pkg::op_prefetch && acc_write_back_dest == dmp_pkg::AWB_REG) begin
                wr_w13 <= '{en: 1'b1, idx: dmp_pkg::W13, data: wb_val};
            end else if (op == dmp_pkg::op_prefetch && acc_write_back_dest == dmp_pkg::AWB_MEM) begin
                mem_wr <= '{en: 1'b1, addr: w13, data: wb_val};
                wr_w13 <= '{en: 1'b1, idx: dmp_pkg::W13, data: w13 + dmp_pkg::WB_STEP};
            end
        end
    end

    // Interrupt status; a new event wins over a clear
    assign irq_event[dmp_pkg::IRQ_OVF_BIT] = (op == dmp_pkg::op_mult || op == dmp_pkg::op_square)
        && (dmp_pkg::acc_ovf(next_acc[0]) || dmp_pkg::acc_ovf(next_acc[1]));
    assign irq_event[dmp_pkg::IRQ_PAGE_BIT] = (op == dmp_pkg::op_page_lit)
        || (op == dmp_pkg::op_page_reg);
    assign irq_clr = (wr_commit && aw_addr == dmp_pkg::IRQ_CLR_OFS && w_strb[0]) ?
                     w_data[dmp_pkg::IRQ_W-1:0] : '0;
    assign next_status = (irq_status & ~irq_clr) | irq_event;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq <= |(next_status & irq_enable);
        end
    end

    // AXI4-Lite write channel
    assign wr_commit = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit = aw_addr == dmp_pkg::CTRL_OFS || aw_addr == dmp_pkg::IRQ_EN_OFS
                    || aw_addr == dmp_pkg::IRQ_CLR_OFS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= dmp_pkg::RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held;
            s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_held;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_commit) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? dmp_pkg::RESP_OKAY : dmp_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-written registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_control_reg <= dmp_pkg::CTRL_RST;
            irq_enable <= '0;
        end else if (wr_commit) begin
            if (aw_addr == dmp_pkg::CTRL_OFS) begin
                if (w_strb[0]) core_control_reg[7:0] <= w_data[7:0];
                if (w_strb[1]) core_control_reg[15:8] <= w_data[15:8];
            end
            if (aw_addr == dmp_pkg::IRQ_EN_OFS && w_strb[0]) begin
                irq_enable <= w_data[dmp_pkg::IRQ_W-1:0];
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= dmp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= dmp_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    dmp_pkg::CTRL_OFS: s_axi_rdata <= {16'h0000, core_control_reg};
                    dmp_pkg::RPAGE_OFS: s_axi_rdata <= {22'h000000, data_read_page};
                    dmp_pkg::WPAGE_OFS: s_axi_rdata <= {23'h000000, data_write_page};
                    dmp_pkg::TPAGE_OFS: s_axi_rdata <= {24'h000000, table_page};
                    dmp_pkg::ACC0_LO_OFS: s_axi_rdata <= acc_q[0][31:0];
                    dmp_pkg::ACC0_HI_OFS: s_axi_rdata <= {24'h000000, acc_q[0][39:32]};
                    dmp_pkg::ACC1_LO_OFS: s_axi_rdata <= acc_q[1][31:0];
                    dmp_pkg::ACC1_HI_OFS: s_axi_rdata <= {24'h000000, acc_q[1][39:32]};
                    dmp_pkg::FLAGS_OFS: s_axi_rdata <= {28'h0000000, acc_flags};
                    dmp_pkg::IRQ_STAT_OFS: s_axi_rdata <= {30'h00000000, irq_status};
                    dmp_pkg::IRQ_EN_OFS: s_axi_rdata <= {30'h00000000, irq_enable};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= (s_axi_araddr == dmp_pkg::IRQ_CLR_OFS) ?
                                       dmp_pkg::RESP_OKAY : dmp_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    logic [15:0] w4_q;
    always_ff @(posedge aclk) begin
        w4_q <= wreg_file[4];
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    page_literal_a: assert property (
        op == dmp_pkg::op_page_lit && page_sel == dmp_pkg::PP_READ
        |=> data_read_page == $past(instr_word[9:0]))
        else $error("literal page load wrong");
    page_register_a: assert property (
        op == dmp_pkg::op_page_reg && page_sel == dmp_pkg::PP_TABLE
        |=> table_page == $past(page_val[7:0]) && $stable(data_read_page))
        else $error("register page load wrong");
    page_flags_a: assert property (
        op == dmp_pkg::op_page_lit || op == dmp_pkg::op_page_reg
        |=> $stable(acc_flags) && $stable(acc_q[0]) && $stable(acc_q[1]))
        else $error("page load touched flags");
    store_no_math_a: assert property (
        op == dmp_pkg::op_prefetch
        |=> $stable(acc_q[0]) && $stable(acc_q[1]) && $stable(acc_flags))
        else $error("prefetch-store changed accumulator");
    x_post_step_a: assert property (
        pf_act && instr_word[9:6] == 4'h1
        |=> x_rd.en && x_rd.addr == $past(wreg_file[dmp_pkg::W8])
            && wr_xptr.en && wr_xptr.data == x_rd.addr + 16'h0002)
        else $error("x post-step wrong");
    y_offset_a: assert property (
        pf_act && instr_word[5:2] == 4'hc
        |=> y_rd.en && !wr_yptr.en ##1 wr_yd.en && wr_yd.data == $past(y_rd_data))
        else $error("y offset fetch wrong");
    mem_writeback_a: assert property (
        op == dmp_pkg::op_prefetch && acc_write_back_dest == dmp_pkg::AWB_MEM
        |=> mem_wr.en && wr_w13.en && wr_w13.data == mem_wr.addr + 16'h0002)
        else $error("memory write-back wrong");
    frac_shift_a: assert property (
        (op == dmp_pkg::op_mult || op == dmp_pkg::op_square)
        && core_control_reg == 16'h0000 && !a_sel
        |=> !acc_q[0][0] && acc_q[0][39:32] == {8{acc_q[0][32]}})
        else $error("fractional result not shifted");
    int_square_a: assert property (
        op == dmp_pkg::op_square && instr_word[17:16] == 2'h0
        && core_control_reg[dmp_pkg::INT_SEL_BIT] && !a_sel
        |=> acc_q[0][31:0] == 32'($signed(w4_q) * $signed(w4_q)))
        else $error("integer square wrong");
    ovf_flags_a: assert property (
        op == dmp_pkg::op_mult
        |=> acc_flags[0] == (acc_q[0][39:31] != {9{acc_q[0][31]}})
            && acc_flags[1] == (acc_q[1][39:31] != {9{acc_q[1][31]}})
            && acc_flags[3:2] == 2'h0)
        else $error("overflow flag wrong");

endmodule : dmp_unit

// ===== testbench.sv
// Self-checking bench for dmp_unit: page loads, multiply, prefetch-store, irq.
// Assumes dmp_pkg is compiled first and registers sit behind AXI4-Lite.
`timescale 1ns/100ps
module testbench;
    logic aclk = 0, aresetn = 0, instr_valid = 0;
    logic [23:0] instr_word = '0;
    logic [15:0][15:0] wreg_file = '0;
    logic [15:0] x_rd_data = 16'h671f, y_rd_data = 16'he3dc;
    dmp_pkg::dmp_wr_port_t wr_xd, wr_yd, wr_xptr, wr_yptr, wr_w13;
    dmp_pkg::dmp_mem_req_t x_rd, y_rd, mem_wr;
    logic [9:0] data_read_page;
    logic [8:0] data_write_page;
    logic [7:0] table_page, s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [3:0] acc_flags, s_axi_wstrb = 4'hf;
    logic irq, s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int n_errors = 0, cmp_count = 0;
    dmp_unit u_dut (.*);
    always #5 aclk = ~aclk;
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        rr = s_axi_bresp;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : axr
    task automatic issue(input logic [23:0] w);
        @(posedge aclk);
        instr_valid <= 1;
        instr_word <= w;
        @(posedge aclk);
        instr_valid <= 0;
        #1;
    endtask : issue
    task automatic finish_test;
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        finish_test;
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        axr(8'h00);
        chk("ctrl", rd, 40'h0);
        axr(8'h40);
        chk("unmapped", rr, dmp_pkg::RESP_SLVERR);
        axw(8'h28, 32'h2);
        chk("bresp", rr, dmp_pkg::RESP_OKAY);
        axw(8'h24, 32'h3);
        chk("ro write", rr, dmp_pkg::RESP_SLVERR);
        wreg_file[2] <= 16'hfea5;
        for (int i = 0; i < 3; i++) issue({12'hfec, i[1:0], 10'h3ff});
        chk("rpage", data_read_page, 10'h3ff);
        chk("wpage", data_write_page, 9'h1ff);
        chk("tpage", table_page, 8'hff);
        for (int i = 0; i < 3; i++) issue({12'hfed, i[1:0], 10'h002});
        chk("rpage", data_read_page, 10'h2a5);
        chk("wpage", data_write_page, 9'h0a5);
        chk("tpage", table_page, 8'ha5);
        chk("flags", acc_flags, 40'h0);
        @(posedge aclk);
        #1;
        chk("irq", irq, 40'h1);
        axw(8'h2c, 32'h2);
        repeat (2) @(posedge aclk);
        #1;
        chk("irq", irq, 40'h0);
        wreg_file[4] <= 16'hc000;
        wreg_file[5] <= 16'h9000;
        wreg_file[8] <= 16'h1780;
        wreg_file[13] <= 16'h2300;
        issue(24'hc02053);
        chk("xaddr", x_rd.addr, 16'h1780);
        chk("xptr", wr_xptr.data, 16'h1782);
        @(posedge aclk);
        #1;
        chk("xd", {wr_xd.idx, wr_xd.data}, {4'h6, 16'h671f});
        axr(8'h10);
        chk("acc lo", rd, 32'h38000000);
        axw(8'h00, 32'h1);
        wreg_file[5] <= 16'h7000;
        issue(24'hc02053);
        axr(8'h10);
        chk("acc lo", rd, 32'he4000000);
        axr(8'h14);
        chk("acc hi", rd, 32'hff);
        issue(24'hc78111);
        chk("wb addr", mem_wr.addr, 16'h2300);
        chk("wb data", mem_wr.data, 16'he400);
        chk("w13", wr_w13.data, 16'h2302);
        wreg_file[11] <= 16'h2000;
        wreg_file[12] <= 16'h0024;
        issue(24'hf01df1);
        chk("sq xaddr", x_rd.addr, 16'h1780);
        chk("sq xptr", wr_xptr.data, 16'h177e);
        chk("yaddr", y_rd.addr, 16'h2024);
        chk("yptr en", wr_yptr.en, 40'h0);
        chk("sq wb", {mem_wr.en, wr_w13.en}, 40'h0);
        @(posedge aclk);
        #1;
        chk("yd", {wr_yd.idx, wr_yd.data}, {4'h7, 16'he3dc});
        chk("xd idx", wr_xd.idx, 4'h5);
        axr(8'h10);
        chk("sq acc", rd, 32'h10000000);
        finish_test;
    end
endmodule : testbench
